// [bench/stcfg_host_model.sv]
// stcfg_host_model: bus master side, issues frame boundaries and data requests
// assumes: the bench commands it on sys_clk, one pulse at a time
`timescale 1ns/1ns
module stcfg_host_model
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       frameGo,    // bench asks for a frame boundary
  input  wire logic       reqGo,      // bench asks for a sensor data request
  input  wire logic [2:0] reqSlot,    // slot of that request
  output logic            frameStart,
  output logic            srcRequest,
  output logic      [2:0] srcReqSlot
);
  // ************************************************************
  // request generation
  // ************************************************************
  // pulses last one cycle; idle slot toggles so a stale value never passes
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      frameStart <= 1'b0;
      srcRequest <= 1'b0;
      srcReqSlot <= 3'h0;
    end
    else
    begin
      frameStart <= frameGo;
      srcRequest <= reqGo;
      srcReqSlot <= reqGo ? reqSlot : ~srcReqSlot;
    end
  end
endmodule : stcfg_host_model

// [bench/stcfg_timing_tb.sv]
// stcfg_timing_tb: random and corner checks of the timing configuration block
// assumes: host model supplies frame and request pulses, bench the rest
`timescale 1ns/1ns
module stcfg_timing_tb;
  // ************************************************************
  // signals and instances
  // ************************************************************
  logic        sys_clk = 1'b0, rstn = 1'b0, crmActive = 1'b0;
  logic        regWrEn = 1'b0, regRdEn = 1'b0, frameGo = 1'b0, reqGo = 1'b0;
  logic        selftestRunDone = 1'b0, selftestPass = 1'b0, faultRaw = 1'b0;
  logic [1:0]  busMode = 2'h0;
  logic [2:0]  reqSlot = 3'h0, srcReqSlot, latencyRef;
  logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, srcEnable = 8'h00;
  logic [7:0]  regRdData, srcUpdateMask, v;
  logic        regParityErr, frameStart, srcRequest, selftest_fail_flag;
  logic        faultIndication, srcSampleStrobe, slewEnable;
  logic [11:0] symbolCycles;
  int          error_cnt = 0, comparisons = 0, cyc = 0, lo, hi;
  int          chipDus[16] = '{10, 20, 25, 26, 26, 27, 28, 29, 30, 31, 32, 33, 35, 40, 45, 50};
  int          limTab[4] = '{8, 1, 4, 2};  // attempts per retry code
  stcfg_timing dut_u (.sys_clk(sys_clk), .rstn(rstn), .busMode(busMode),
    .crmActive(crmActive), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regParityErr(regParityErr),
    .frameStart(frameStart), .selftestRunDone(selftestRunDone),
    .selftestPass(selftestPass), .faultRaw(faultRaw), .srcEnable(srcEnable),
    .srcRequest(srcRequest), .srcReqSlot(srcReqSlot),
    .selftest_fail_flag(selftest_fail_flag), .faultIndication(faultIndication),
    .latencyRef(latencyRef), .srcSampleStrobe(srcSampleStrobe),
    .srcUpdateMask(srcUpdateMask), .symbolCycles(symbolCycles), .slewEnable(slewEnable));
  stcfg_host_model host_u (.sys_clk(sys_clk), .rstn(rstn), .frameGo(frameGo),
    .reqGo(reqGo), .reqSlot(reqSlot), .frameStart(frameStart),
    .srcRequest(srcRequest), .srcReqSlot(srcReqSlot));
  // 4 ns clock and a watchdog that cuts a hang short
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc > 60000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  // ************************************************************
  // tasks and expectations
  // ************************************************************
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wrap_up();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task reset();
    rstn = 1'b0;
    tick(3);
    rstn = 1'b1;
  endtask : reset
  task wr(input logic [7:0] a, input logic [7:0] d);
    regWrEn = 1'b1; regAddr = a; regWrData = d;
    tick(1);
    regWrEn = 1'b0;
    tick(1);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    regRdEn = 1'b1; regAddr = a;
    tick(1);
    regRdEn = 1'b0;
    tick(1);
    chk(regRdData, e);
    chk(regParityErr, 1'b0);
  endtask : rd
  // write, then a frame boundary, then let the decode settle
  task cfg(input logic [1:0] m, input logic crm, input logic [7:0] d);
    busMode = m; crmActive = crm;
    wr(stcfg_pkg::STCFG_REG_ADDR, d);
    frameGo = 1'b1;
    tick(1);
    frameGo = 1'b0;
    tick(5);
  endtask : cfg
  task req(input logic [2:0] s, input logic [8:0] e);
    reqSlot = s; reqGo = 1'b1;
    tick(1);
    reqGo = 1'b0;
    tick(1);
    chk({7'h00, srcSampleStrobe, srcUpdateMask}, {7'h00, e});
  endtask : req
  task fault(input logic e);
    faultRaw = 1'b1;
    tick(2);
    chk(faultIndication, 1'b1);
    faultRaw = 1'b0;
    tick(3);
    chk(faultIndication, e);
  endtask : fault
  task attempt(input logic p);
    selftestPass = p; selftestRunDone = 1'b1;
    tick(1);
    selftestRunDone = 1'b0; selftestPass = 1'b0;
    tick(2);
  endtask : attempt
  // {slew, cycles} for a mode and code
  function logic [12:0] exp_sym(input logic [1:0] m, input logic crm, input logic [3:0] c);
    if (m == 2'h1)
      return {1'b1, 12'(c[3] ? stcfg_pkg::STCFG_PSI5_SLOW_CYC : stcfg_pkg::STCFG_PSI5_FAST_CYC)};
    if (m != 2'h0)
      return 13'h0000;
    if (crm)
      return {1'b1, 12'(stcfg_pkg::STCFG_CRM_CHIP_CYC)};
    return {c > 4'h1, 12'(chipDus[c] * stcfg_pkg::STCFG_CLK_MHZ / 10)};
  endfunction : exp_sym
  function logic [2:0] exp_lat(input logic [1:0] m, input logic ss);
    case (m)
      2'h0: return ss ? stcfg_pkg::STCFG_LAT_CMDEDGE : stcfg_pkg::STCFG_LAT_RSPSTART;
      2'h1: return ss ? stcfg_pkg::STCFG_LAT_SYNC : stcfg_pkg::STCFG_LAT_SLOT;
      2'h2: return ss ? stcfg_pkg::STCFG_LAT_LOWREQ : stcfg_pkg::STCFG_LAT_OWNREQ;
      default: return stcfg_pkg::STCFG_LAT_NONE;
    endcase
  endfunction : exp_lat
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    void'($urandom(15842));
    reset();
    rd(stcfg_pkg::STCFG_REG_ADDR, stcfg_pkg::STCFG_RESET_VAL);
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($urandom());
      busMode = 2'(i);
      wr(stcfg_pkg::STCFG_REG_ADDR, v);
      wr(8'h24, ~v);
      rd(stcfg_pkg::STCFG_REG_ADDR, v);
      rd(8'h24, 8'h00);
    end
    // every mode with every code, random upper fields
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 16; c++)
      begin
        v = {4'($urandom()), 4'(c)};
        cfg(2'(m), 1'b0, v);
        chk({slewEnable, symbolCycles}, exp_sym(2'(m), 1'b0, v[3:0]));
        chk(latencyRef, exp_lat(2'(m), v[4]));
      end
    cfg(2'h0, 1'b1, 8'h02);
    chk({slewEnable, symbolCycles}, exp_sym(2'h0, 1'b1, 4'h2));
    // a write without a frame boundary must not reach the decode
    cfg(2'h0, 1'b0, 8'h0F);
    wr(stcfg_pkg::STCFG_REG_ADDR, 8'h00);
    tick(5);
    chk({slewEnable, symbolCycles}, exp_sym(2'h0, 1'b0, 4'hF));
    // fault clearing: DSI3 ignores latch bit, PSI5 latches until reset
    cfg(2'h0, 1'b0, 8'h20);
    fault(1'b0);
    cfg(2'h1, 1'b0, 8'h20);
    fault(1'b1);
    cfg(2'h1, 1'b0, 8'h00);
    chk(faultIndication, 1'b1);
    reset();
    cfg(2'h1, 1'b0, 8'h00);
    fault(1'b0);
    // SPI sampling, simultaneous then each slot on its own request
    for (int i = 0; i < 6; i++)
    begin
      srcEnable = 8'($urandom()) | 8'h80;
      srcEnable[0] = i[0];
      if (srcEnable == 8'h80)
        srcEnable[4] = 1'b1;  // keep the lowest slot below the highest
      lo = 0;
      while (!srcEnable[lo])
        lo++;
      hi = 7;
      cfg(2'h2, 1'b0, 8'h10);
      req(3'(lo), {1'b1, srcEnable});
      req(3'(hi), 9'h000);
      cfg(2'h2, 1'b0, 8'h00);
      req(3'(hi), {1'b1, 8'h80});
      srcEnable[lo] = 1'b0;
      req(3'(lo), 9'h000);
    end
    // self-test limit per code, fresh reset each time
    for (int c = 0; c < 4; c++)
    begin
      reset();
      cfg(2'h1, 1'b0, {2'(c), 6'h00});
      repeat (limTab[c] - 1) attempt(1'b0);
      attempt(1'b1);
      chk(selftest_fail_flag, 1'b0);
      attempt(1'b0);
      chk(selftest_fail_flag, 1'b1);
    end
    reset();
    cfg(2'h0, 1'b0, 8'h40);
    attempt(1'b0);
    chk(selftest_fail_flag, 1'b0);
    wrap_up();
  end
endmodule : stcfg_timing_tb

// [core/stcfg_chip_rom.sv]
// stcfg_chip_rom: registered lookup of DSI3 periodic chip time per symbol code
// assumes: same clock and synchronous active-low reset as the top
`timescale 1ns/1ns
module stcfg_chip_rom
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  code,
  output logic      [11:0] chipCycles
);

  // ************************************************************
  // chip time table, tenths of microseconds
  // ************************************************************
  function automatic logic [7:0] chipDus(input logic [3:0] c);
    case (c)
      4'h0: chipDus = 8'd10;
      4'h1: chipDus = 8'd20;
      4'h2: chipDus = 8'd25;
      4'h3: chipDus = 8'd26;
      4'h4: chipDus = 8'd26;
      4'h5: chipDus = 8'd27;
      4'h6: chipDus = 8'd28;
      4'h7: chipDus = 8'd29;
      4'h8: chipDus = 8'd30;
      4'h9: chipDus = 8'd31;
      4'hA: chipDus = 8'd32;
      4'hB: chipDus = 8'd33;
      4'hC: chipDus = 8'd35;
      4'hD: chipDus = 8'd40;
      4'hE: chipDus = 8'd45;
      default: chipDus = 8'd50;
    endcase
  endfunction : chipDus

  // registered read: cycles = tenths * 25
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      chipCycles <= 12'h000;
    else
      chipCycles <= 12'(chipDus(code) * 12'd25);
  end

endmodule : stcfg_chip_rom

// [core/stcfg_pkg.sv]
// stcfg_pkg: constants shared by the symbol timing configuration block
// assumes: 250 MHz sys_clk, 8-bit register reached over a simple register port
package stcfg_pkg;

  // ************************************************************
  // register layout
  // ************************************************************
  localparam logic [7:0] STCFG_REG_ADDR   = 8'h23;      // register index in the array
  localparam logic [7:0] STCFG_RESET_VAL  = 8'h00;      // value after reset
  localparam int         STCFG_RETRY_MSB  = 7;          // selftest_retry_limit [7:6]
  localparam int         STCFG_RETRY_LSB  = 6;
  localparam int         STCFG_LATCH_BIT  = 5;          // fault_latch_enable
  localparam int         STCFG_SIMUL_BIT  = 4;          // simultaneous_sample_select
  localparam int         STCFG_SYM_MSB    = 3;          // symbol_period_code [3:0]

  // ************************************************************
  // bus modes
  // ************************************************************
  typedef enum logic [1:0]
  {
    STCFG_MODE_DSI3 = 2'b00,
    STCFG_MODE_PSI5 = 2'b01,
    STCFG_MODE_SPI  = 2'b10,
    STCFG_MODE_I2C  = 2'b11
  } stcfg_mode_t;

  // latency reference selections
  typedef enum logic [2:0]
  {
    STCFG_LAT_NONE     = 3'b000,
    STCFG_LAT_RSPSTART = 3'b001,
    STCFG_LAT_CMDEDGE  = 3'b010,
    STCFG_LAT_SLOT     = 3'b011,
    STCFG_LAT_SYNC     = 3'b100,
    STCFG_LAT_OWNREQ   = 3'b101,
    STCFG_LAT_LOWREQ   = 3'b110
  } stcfg_lat_t;

  // ************************************************************
  // timing: periods in tenths of a microsecond, then in cycles
  // ************************************************************
  localparam int STCFG_CLK_MHZ        = 250;
  localparam int STCFG_CRM_CHIP_DUS   = 50;             // 5.0 us fixed command-mode chip
  localparam int STCFG_PSI5_FAST_DUS  = 53;             // 5.3 us bit time
  localparam int STCFG_PSI5_SLOW_DUS  = 80;             // 8.0 us bit time
  localparam int STCFG_CRM_CHIP_CYC   = STCFG_CRM_CHIP_DUS * STCFG_CLK_MHZ / 10;
  localparam int STCFG_PSI5_FAST_CYC  = STCFG_PSI5_FAST_DUS * STCFG_CLK_MHZ / 10;
  localparam int STCFG_PSI5_SLOW_CYC  = STCFG_PSI5_SLOW_DUS * STCFG_CLK_MHZ / 10;
  localparam int STCFG_SRC_COUNT      = 8;              // source slots
  localparam int STCFG_SLOT_CODE_W    = 3;

endpackage : stcfg_pkg

// [core/stcfg_timing.sv]
// stcfg_timing: symbol timing configuration register and its decode
// assumes: register port and mode come from on-chip logic on sys_clk; frame
// boundaries and sensor events arrive as one-cycle pulses from the same clock
`timescale 1ns/1ns
module stcfg_timing
(
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic [1:0]          busMode,          // stcfg_mode_t
  input  wire logic                crmActive,        // DSI3 command and response mode
  input  wire logic                regWrEn,          // register write strobe
  input  wire logic                regRdEn,          // register read strobe
  input  wire logic [7:0]          regAddr,
  input  wire logic [7:0]          regWrData,
  output logic      [7:0]          regRdData,
  output logic                     regParityErr,     // array check mismatch
  input  wire logic                frameStart,       // frame or sampling period boundary
  input  wire logic                selftestRunDone,  // one self-test attempt ended
  input  wire logic                selftestPass,
  input  wire logic                faultRaw,         // live internal fault level
  input  wire logic [7:0]          srcEnable,        // enabled source slots
  input  wire logic                srcRequest,       // sensor data request pulse
  input  wire logic [2:0]          srcReqSlot,
  output logic                     selftest_fail_flag,
  output logic                     faultIndication,
  output logic [2:0]               latencyRef,       // stcfg_lat_t
  output logic                     srcSampleStrobe,  // take new sample data
  output logic [7:0]               srcUpdateMask,    // slots refreshed this strobe
  output logic [11:0]              symbolCycles,
  output logic                     slewEnable
);

  // ************************************************************
  // register and its shadow
  // ************************************************************
  logic [7:0]  cfg_reg;          // software view
  logic        cfgPar_reg;       // stored parity
  logic [7:0]  act_reg;          // value applied to frames
  logic [11:0] romCycles;        // dsi3 periodic chip cycles
  logic [3:0]  tryCount_reg;     // failed PSI5 self-test attempts so far
  logic [3:0]  tryLimit;         // decoded attempt cap
  logic [2:0]  lowSlot;          // lowest enabled slot
  logic        hit;              // register selected
  logic        faultLatched_reg; // fault caught while latching was on

  assign hit = (regAddr == stcfg_pkg::STCFG_REG_ADDR);

  // software write, all modes accepted
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      cfg_reg    <= stcfg_pkg::STCFG_RESET_VAL;
      cfgPar_reg <= ^stcfg_pkg::STCFG_RESET_VAL;
    end
    else if (regWrEn && hit)
    begin
      cfg_reg    <= regWrData;
      cfgPar_reg <= ^regWrData;
    end
  end

  // read data and array error check
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      regRdData    <= 8'h00;
      regParityErr <= 1'b0;
    end
    else
    begin
      if (regRdEn)
        regRdData <= hit ? cfg_reg : 8'h00;
      regParityErr <= (^cfg_reg) != cfgPar_reg;
    end
  end

  // apply new fields only at a frame boundary
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      act_reg <= stcfg_pkg::STCFG_RESET_VAL;
    else if (frameStart)
      act_reg <= cfg_reg;
  end

  // ************************************************************
  // self-test retry limit
  // ************************************************************
  always_comb
  begin
    case (act_reg[stcfg_pkg::STCFG_RETRY_MSB:stcfg_pkg::STCFG_RETRY_LSB])
      2'b00:   tryLimit = 4'd8;
      2'b01:   tryLimit = 4'd1;
      2'b10:   tryLimit = 4'd4;
      default: tryLimit = 4'd2;
    endcase
  end

  // count failed attempts in PSI5 mode only; flag once the cap is reached
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      tryCount_reg       <= 4'h0;
      selftest_fail_flag <= 1'b0;
    end
    else if (busMode == stcfg_pkg::STCFG_MODE_PSI5 && selftestRunDone
             && !selftestPass && !selftest_fail_flag)
    begin
      tryCount_reg <= tryCount_reg + 4'd1;
      if (tryCount_reg + 4'd1 >= tryLimit)
        selftest_fail_flag <= 1'b1;
    end
  end

  // ************************************************************
  // fault latching
  // ************************************************************
  // a fault seen while latching is on stays held until reset, even if the
  // latch bit is cleared later; only reset releases it
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      faultLatched_reg <= 1'b0;
    else if ((faultRaw || faultIndication) && busMode == stcfg_pkg::STCFG_MODE_PSI5
             && act_reg[stcfg_pkg::STCFG_LATCH_BIT])
      faultLatched_reg <= 1'b1;
  end

  // set wins over clear; clear only when nothing holds the fault
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      faultIndication <= 1'b0;
    else if (faultRaw)
      faultIndication <= 1'b1;
    else if (!faultLatched_reg
             && !(busMode == stcfg_pkg::STCFG_MODE_PSI5 && act_reg[stcfg_pkg::STCFG_LATCH_BIT]))
      faultIndication <= 1'b0;
  end

  // ************************************************************
  // latency reference
  // ************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      latencyRef <= stcfg_pkg::STCFG_LAT_NONE;
    else
    begin
      case (stcfg_pkg::stcfg_mode_t'(busMode))
        stcfg_pkg::STCFG_MODE_DSI3:
          latencyRef <= act_reg[stcfg_pkg::STCFG_SIMUL_BIT] ?
            stcfg_pkg::STCFG_LAT_CMDEDGE : stcfg_pkg::STCFG_LAT_RSPSTART;
        stcfg_pkg::STCFG_MODE_PSI5:
          latencyRef <= act_reg[stcfg_pkg::STCFG_SIMUL_BIT] ?
            stcfg_pkg::STCFG_LAT_SYNC : stcfg_pkg::STCFG_LAT_SLOT;
        stcfg_pkg::STCFG_MODE_SPI:
          latencyRef <= act_reg[stcfg_pkg::STCFG_SIMUL_BIT] ?
            stcfg_pkg::STCFG_LAT_LOWREQ : stcfg_pkg::STCFG_LAT_OWNREQ;
        default:
          latencyRef <= stcfg_pkg::STCFG_LAT_NONE;
      endcase
    end
  end

  // lowest enabled slot, slot zero first
  always_comb
  begin
    lowSlot = 3'd0;
    for (int i = stcfg_pkg::STCFG_SRC_COUNT - 1; i >= 0; i--)
      if (srcEnable[i])
        lowSlot = 3'(i);
  end

  // sample strobes for spi requests
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      srcSampleStrobe <= 1'b0;
      srcUpdateMask   <= 8'h00;
    end
    else if (busMode == stcfg_pkg::STCFG_MODE_SPI && srcRequest && srcEnable[srcReqSlot])
    begin
      if (act_reg[stcfg_pkg::STCFG_SIMUL_BIT])
      begin
        srcSampleStrobe <= (srcReqSlot == lowSlot);
        srcUpdateMask   <= (srcReqSlot == lowSlot) ? srcEnable : 8'h00;
      end
      else
      begin
        srcSampleStrobe <= 1'b1;
        srcUpdateMask   <= 8'h01 << srcReqSlot;
      end
    end
    else
    begin
      srcSampleStrobe <= 1'b0;
      srcUpdateMask   <= 8'h00;
    end
  end

  // ************************************************************
  // symbol period and slew
  // ************************************************************
  stcfg_chip_rom u_rom
  (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .code       (act_reg[stcfg_pkg::STCFG_SYM_MSB:0]),
    .chipCycles (romCycles)
  );

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      symbolCycles <= 12'h000;
      slewEnable   <= 1'b0;
    end
    else
    begin
      case (stcfg_pkg::stcfg_mode_t'(busMode))
        stcfg_pkg::STCFG_MODE_DSI3:
        begin
          if (crmActive)
          begin
            symbolCycles <= 12'(stcfg_pkg::STCFG_CRM_CHIP_CYC);
            slewEnable   <= 1'b1;
          end
          else
          begin
            symbolCycles <= romCycles;
            slewEnable   <= (act_reg[3:1] != 3'b000);
          end
        end
        stcfg_pkg::STCFG_MODE_PSI5:
        begin
          symbolCycles <= act_reg[stcfg_pkg::STCFG_SYM_MSB] ?
            12'(stcfg_pkg::STCFG_PSI5_SLOW_CYC) : 12'(stcfg_pkg::STCFG_PSI5_FAST_CYC);
          slewEnable   <= 1'b1;
        end
        default:
        begin
          symbolCycles <= 12'h000;
          slewEnable   <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_latch_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    faultIndication && busMode == stcfg_pkg::STCFG_MODE_PSI5 && act_reg[5]
    && $stable(busMode) |=> faultIndication)
    else $error("latched fault dropped");
  chk_latch_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
    faultLatched_reg |=> faultIndication)
    else $error("held fault released before reset");
  chk_auto_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    !faultRaw && !faultLatched_reg
    && !(busMode == stcfg_pkg::STCFG_MODE_PSI5 && act_reg[5]) |=> !faultIndication)
    else $error("fault not cleared");
  chk_crm_chip: assert property (@(posedge sys_clk) disable iff (!rstn)
    busMode == stcfg_pkg::STCFG_MODE_DSI3 && crmActive |=> symbolCycles == 12'd1250 && slewEnable)
    else $error("crm chip time wrong");
  chk_psi5_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
    busMode == stcfg_pkg::STCFG_MODE_PSI5 && !act_reg[3] |=> symbolCycles == 12'd1325)
    else $error("psi5 bit time wrong");
  chk_psi5_ref: assert property (@(posedge sys_clk) disable iff (!rstn)
    busMode == stcfg_pkg::STCFG_MODE_PSI5 && act_reg[4] |=> latencyRef == 3'b100)
    else $error("psi5 latency ref wrong");
  chk_dsi3_ref: assert property (@(posedge sys_clk) disable iff (!rstn)
    busMode == stcfg_pkg::STCFG_MODE_DSI3 && !act_reg[4] |=> latencyRef == 3'b001)
    else $error("dsi3 latency ref wrong");
  chk_apply_frame: assert property (@(posedge sys_clk) disable iff (!rstn)
    !frameStart |=> $stable(act_reg))
    else $error("config changed mid frame");
  chk_spi_stale: assert property (@(posedge sys_clk) disable iff (!rstn)
    busMode == stcfg_pkg::STCFG_MODE_SPI && act_reg[4] && srcRequest && srcReqSlot != lowSlot
    |=> !srcSampleStrobe)
    else $error("update without lowest request");
  chk_fail_cap: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(selftest_fail_flag) |-> tryCount_reg == tryLimit)
    else $error("self-test cap wrong");

endmodule : stcfg_timing
